// >>> design/host_port_device.sv
// Device end of the host memory port: address latch, long/short reads, writes,
// internal data and program memory, overlay control register, strap capture.
// Assumes link inputs synchronous to clock; the host keeps its own timing.
//
// Contract
// - Host holds address across latch end
// - Host latches only after acknowledge low
// - Cycle starts only after latch ended
// - Host reads only while acknowledge low
// - Read start drives acknowledge high
// - Long read: data before acknowledge low
// - Host holds read until acknowledge low
// - Read start drives previous data word
// - Program word in halves; hold two/one
// - Short read ends within hold window
// - Short read only with bit clear
// - Hosts should prefer short-read-only style
// - Overlay bit 14 enables short-read-only
// - Short-read-only keeps previous data driven
// - Strap set enables host port pins
// - Strap captured at reset release
`timescale 1ns/1ps
`default_nettype none

module host_port_device
    import host_port_pkg::*;
#(
    parameter int ADDR_W = 14
) (
    input wire logic clock,
    input wire logic sys_rst,
    host_port_if.device link,
    input wire logic strapHostPort,
    input wire logic coreOverlayWrite,
    input wire logic [host_port_pkg::DATA_W-1:0] coreOverlayData,
    output logic portEnabled,
    output logic shortReadOnly,
    output logic busy
);
    import host_port_pkg::*;

    typedef enum logic [2:0] {
        D_IDLE,
        D_HOLD,
        D_LATE,
        D_READY,
        D_WRITE
    } dev_state_e;

    // Memory size must fit below the space select bit
    if (ADDR_W < 1 || ADDR_W > ADDR_FIELD_W) begin : g_bad_addr_w
        $error("ADDR_W must be 1 to 14");
    end

    dev_state_e state_r;
    logic strapDone_r;
    logic portEn_r;
    logic ackN_r;
    logic oeN_r;
    logic [CNT_W-1:0] holdCnt_r;
    logic [DATA_W-1:0] outWord_r;
    logic [DATA_W-1:0] stash_r;
    logic [DATA_W-1:0] wrData_r;
    logic [DATA_W-1:0] addr_r;
    logic half_r;
    logic [DATA_W-1:0] overlay_r;
    logic [DATA_W-1:0] pmStage_r;
    logic [DATA_W-1:0] dmem [2**ADDR_W];
    logic [PM_W-1:0] pmem [2**ADDR_W];

    logic selOn;
    logic latchOn;
    logic rdOn;
    logic wrOn;
    logic isPm;
    logic isOvl;
    logic [ADDR_W-1:0] idx;
    logic [DATA_W-1:0] fetchWord;
    logic fetchNow;
    logic advance;
    logic commit;

    // Strap taken once, at the first edge after reset release
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strapDone_r <= 1'b0;
            portEn_r <= 1'b0;
        end
        else if (!strapDone_r)
        begin
            strapDone_r <= 1'b1;
            portEn_r <= strapHostPort;
        end
    end

    // Link decode, ignored while the port is not enabled
    assign selOn = portEn_r && !link.portSelectN;
    assign latchOn = selOn && link.addrLatch;
    assign rdOn = selOn && !link.readStrobeN && !latchOn;
    assign wrOn = selOn && !link.writeStrobeN && !latchOn;

    // Word selected by the latched address
    assign isPm = addr_r[PM_SEL_BIT];
    assign isOvl = !isPm && (addr_r == OVERLAY_OFFSET);
    assign idx = addr_r[ADDR_W-1:0];
    always_comb
    begin
        if (isOvl)
            fetchWord = overlay_r;
        else if (isPm && half_r)
            fetchWord = {8'h00, pmem[idx][7:0]};
        else if (isPm)
            fetchWord = pmem[idx][PM_W-1:8];
        else
            fetchWord = dmem[idx];
    end

    // Fetch point for the sequencer; advance and commit for the address and memory processes
    assign fetchNow = (state_r == D_HOLD || state_r == D_LATE) && holdCnt_r == '0;
    assign advance = (state_r == D_READY && !rdOn) || (state_r == D_LATE && holdCnt_r == '0)
        || commit;
    assign commit = state_r == D_WRITE && !wrOn;

    // Cycle sequencing, acknowledge and bus drive
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= D_IDLE;
            ackN_r <= 1'b0;
            oeN_r <= 1'b1;
            holdCnt_r <= '0;
            outWord_r <= '0;
            stash_r <= '0;
            wrData_r <= '0;
        end
        else
        begin
            unique case (state_r)
                D_IDLE:
                begin
                    ackN_r <= 1'b0;
                    if (rdOn)
                    begin
                        state_r <= D_HOLD;
                        ackN_r <= 1'b1;
                        oeN_r <= 1'b0;
                        if (isPm && half_r)
                            holdCnt_r <= CNT_W'(HOLD_PM2_CYC);
                        else
                            holdCnt_r <= CNT_W'(HOLD_DM_CYC);
                    end
                    else if (wrOn)
                    begin
                        state_r <= D_WRITE;
                        ackN_r <= 1'b1;
                        wrData_r <= link.busLevel;
                    end
                end
                D_HOLD:
                begin
                    if (!rdOn)
                    begin
                        // Short read ended early; finish the fetch off the bus
                        oeN_r <= 1'b1;
                        state_r <= D_LATE;
                    end
                    else if (fetchNow)
                    begin
                        stash_r <= fetchWord;
                        if (!shortReadOnly)
                            outWord_r <= fetchWord;
                        state_r <= D_READY;
                    end
                    else
                        holdCnt_r <= holdCnt_r - CNT_W'(1);
                end
                D_LATE:
                begin
                    if (fetchNow)
                    begin
                        stash_r <= fetchWord;
                        outWord_r <= fetchWord;
                        ackN_r <= 1'b0;
                        state_r <= D_IDLE;
                    end
                    else
                        holdCnt_r <= holdCnt_r - CNT_W'(1);
                end
                D_READY:
                begin
                    // Word already stands on the bus for a cycle
                    ackN_r <= 1'b0;
                    if (!rdOn)
                    begin
                        oeN_r <= 1'b1;
                        outWord_r <= stash_r;
                        state_r <= D_IDLE;
                    end
                end
                D_WRITE:
                begin
                    if (wrOn)
                        wrData_r <= link.busLevel;
                    else
                    begin
                        ackN_r <= 1'b0;
                        state_r <= D_IDLE;
                    end
                end
            endcase
        end
    end

    // Latched address and program word half
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            addr_r <= '0;
            half_r <= 1'b0;
        end
        else if (state_r == D_IDLE && latchOn)
        begin
            addr_r <= link.busLevel;
            half_r <= 1'b0;
        end
        else if (advance)
        begin
            if (isPm && !half_r)
                half_r <= 1'b1;
            else
            begin
                half_r <= 1'b0;
                addr_r <= {addr_r[DATA_W-1:ADDR_FIELD_W],
                    addr_r[ADDR_FIELD_W-1:0] + ADDR_FIELD_W'(1)};
            end
        end
    end

    // Overlay control, written by the host or the core
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            overlay_r <= OVERLAY_RESET;
        else if (commit && isOvl)
            overlay_r <= wrData_r;
        else if (coreOverlayWrite)
            overlay_r <= coreOverlayData;
    end

    // Memory writes; program words commit on the second half
    always_ff @(posedge clock)
    begin
        if (commit && !isOvl)
        begin
            if (!isPm)
                dmem[idx] <= wrData_r;
            else if (!half_r)
                pmStage_r <= wrData_r;
            else
                pmem[idx] <= {pmStage_r, wrData_r[7:0]};
        end
    end

    assign shortReadOnly = overlay_r[SRO_BIT];
    assign portEnabled = portEn_r;
    assign busy = state_r != D_IDLE;
    assign link.acknowledgeN = portEn_r ? ackN_r : 1'b1;
    assign link.devBusOeN = portEn_r ? oeN_r : 1'b1;
    assign link.devBusOut = outWord_r;

endmodule : host_port_device

`default_nettype wire

// >>> design/host_port_host.sv
// Host end of the memory port: AHB-Lite register slave that runs address latch,
// read (long or short) and write cycles on the link, paced by acknowledge.
// Assumes a single AHB-Lite master issuing single word transfers.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module host_port_host
    import host_port_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    host_port_if.host link,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import host_port_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE,
        H_WAIT_ACK,
        H_LATCH,
        H_LATCH_END,
        H_READ,
        H_WRITE,
        H_GAP
    } host_state_e;

    host_state_e state_r;
    host_cmd_e cmd_r;
    logic short_r;
    logic done_r;
    logic sawBusy_r;
    logic [CNT_W-1:0] cnt_r;
    logic [DATA_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] rdata_r;
    logic dpRead_r;
    logic dpWrite_r;
    logic rdOut_r;
    logic [7:0] dpAddr_r;
    logic [31:0] hrdata_r;
    logic apValid;
    logic cmdWrite;
    logic [31:0] readMux;

    // AHB address phase and register read mux
    assign apValid = hsel && htrans[1] && hready;
    assign cmdWrite = dpWrite_r && dpAddr_r == REG_CTRL && state_r == H_IDLE;
    always_comb
    begin
        unique case (dpAddr_r)
            REG_CTRL: readMux = {29'h0, short_r, cmd_r};
            REG_ADDR: readMux = {16'h0, addr_r};
            REG_WDATA: readMux = {16'h0, wdata_r};
            REG_RDATA: readMux = {16'h0, rdata_r};
            REG_STATUS: readMux = {30'h0, done_r, state_r != H_IDLE};
            default: readMux = 32'h0;
        endcase
    end

    // Bus slave: writes zero wait, reads one wait state
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dpRead_r <= 1'b0;
            dpWrite_r <= 1'b0;
            rdOut_r <= 1'b0;
            dpAddr_r <= 8'h00;
            hrdata_r <= 32'h0;
        end
        else if (apValid)
        begin
            dpRead_r <= !hwrite;
            dpWrite_r <= hwrite;
            dpAddr_r <= haddr[7:0];
            rdOut_r <= 1'b0;
        end
        else if (dpRead_r && !rdOut_r)
        begin
            hrdata_r <= readMux;
            rdOut_r <= 1'b1;
        end
        else if (hready)
        begin
            dpRead_r <= 1'b0;
            dpWrite_r <= 1'b0;
        end
    end

    // Software-written registers
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            addr_r <= '0;
            wdata_r <= '0;
            short_r <= 1'b0;
        end
        else if (dpWrite_r)
        begin
            if (dpAddr_r == REG_ADDR)
                addr_r <= hwdata[DATA_W-1:0];
            if (dpAddr_r == REG_WDATA)
                wdata_r <= hwdata[DATA_W-1:0];
            if (cmdWrite)
                short_r <= hwdata[CTRL_SHORT_BIT];
        end
    end

    // Link cycle sequencer
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= H_IDLE;
            cmd_r <= CMD_NONE;
            done_r <= 1'b0;
            sawBusy_r <= 1'b0;
            cnt_r <= '0;
            rdata_r <= '0;
            link.portSelectN <= 1'b1;
            link.addrLatch <= 1'b0;
            link.readStrobeN <= 1'b1;
            link.writeStrobeN <= 1'b1;
            link.hostBusOeN <= 1'b1;
            link.hostBusOut <= '0;
        end
        else
        begin
            unique case (state_r)
                H_IDLE:
                begin
                    if (cmdWrite && hwdata[1:0] != 2'b00)
                    begin
                        cmd_r <= host_cmd_e'(hwdata[CTRL_CMD_LSB +: 2]);
                        done_r <= 1'b0;
                        state_r <= H_WAIT_ACK;
                    end
                end
                H_WAIT_ACK:
                begin
                    if (!link.acknowledgeN)
                    begin
                        link.portSelectN <= 1'b0;
                        sawBusy_r <= 1'b0;
                        if (cmd_r == CMD_LATCH)
                        begin
                            link.addrLatch <= 1'b1;
                            link.hostBusOut <= addr_r;
                            link.hostBusOeN <= 1'b0;
                            cnt_r <= CNT_W'(LATCH_MIN_CYC - 1);
                            state_r <= H_LATCH;
                        end
                        else if (cmd_r == CMD_READ)
                        begin
                            link.readStrobeN <= 1'b0;
                            cnt_r <= CNT_W'(READ_MIN_CYC - 1);
                            state_r <= H_READ;
                        end
                        else
                        begin
                            link.writeStrobeN <= 1'b0;
                            link.hostBusOut <= wdata_r;
                            link.hostBusOeN <= 1'b0;
                            cnt_r <= CNT_W'(READ_MIN_CYC - 1);
                            state_r <= H_WRITE;
                        end
                    end
                end
                H_LATCH:
                begin
                    if (cnt_r == '0)
                    begin
                        link.addrLatch <= 1'b0;
                        link.portSelectN <= 1'b1;
                        cnt_r <= CNT_W'(ADDR_HOLD_CYC - 1);
                        state_r <= H_LATCH_END;
                    end
                    else
                        cnt_r <= cnt_r - CNT_W'(1);
                end
                H_LATCH_END:
                begin
                    // Address held past latch end, then bus released
                    if (cnt_r == '0)
                    begin
                        link.hostBusOeN <= 1'b1;
                        cnt_r <= CNT_W'(GAP_CYC - 1);
                        state_r <= H_GAP;
                    end
                    else
                        cnt_r <= cnt_r - CNT_W'(1);
                end
                H_READ:
                begin
                    if (link.acknowledgeN)
                        sawBusy_r <= 1'b1;
                    if (cnt_r != '0)
                        cnt_r <= cnt_r - CNT_W'(1);
                    else if (short_r || (sawBusy_r && !link.acknowledgeN))
                    begin
                        rdata_r <= link.busLevel;
                        link.readStrobeN <= 1'b1;
                        link.portSelectN <= 1'b1;
                        state_r <= H_GAP;
                    end
                end
                H_WRITE:
                begin
                    if (cnt_r == '0)
                    begin
                        link.writeStrobeN <= 1'b1;
                        link.portSelectN <= 1'b1;
                        link.hostBusOeN <= 1'b1;
                        state_r <= H_GAP;
                    end
                    else
                        cnt_r <= cnt_r - CNT_W'(1);
                end
                H_GAP:
                begin
                    // Spacing before the next cycle may start
                    if (cnt_r == '0)
                    begin
                        done_r <= 1'b1;
                        state_r <= H_IDLE;
                    end
                    else
                        cnt_r <= cnt_r - CNT_W'(1);
                end
            endcase
        end
    end

    assign hreadyout = !dpRead_r || rdOut_r;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

endmodule : host_port_host

`default_nettype wire

// >>> design/host_port_if.sv
// Link between the host controller and the device's host memory port.
// The shared bus is resolved here from both ends' output enables (low = driving);
// an undriven bus reads as all ones, like a pulled-up wire.
`timescale 1ns/1ps
`default_nettype none

interface host_port_if;
    import host_port_pkg::*;

    logic portSelectN;
    logic addrLatch;
    logic readStrobeN;
    logic writeStrobeN;
    logic acknowledgeN;
    logic [DATA_W-1:0] devBusOut;
    logic devBusOeN;
    logic [DATA_W-1:0] hostBusOut;
    logic hostBusOeN;
    logic [DATA_W-1:0] busLevel;

    // Level on the shared address/data bus
    assign busLevel = !devBusOeN ? devBusOut : (!hostBusOeN ? hostBusOut : '1);

    modport device (
        input portSelectN,
        input addrLatch,
        input readStrobeN,
        input writeStrobeN,
        input busLevel,
        output acknowledgeN,
        output devBusOut,
        output devBusOeN
    );

    modport host (
        output portSelectN,
        output addrLatch,
        output readStrobeN,
        output writeStrobeN,
        output hostBusOut,
        output hostBusOeN,
        input busLevel,
        input acknowledgeN
    );

endinterface : host_port_if

`default_nettype wire

// >>> design/host_port_pkg.sv
// Shared constants for the parallel host memory port: device map, link timing in
// core cycles and the host controller's own register map.
// Assumes one 200 MHz core clock shared by both ends.
`default_nettype none

package host_port_pkg;

    // Link word and memory word widths
    localparam int DATA_W = 16;
    localparam int PM_W = 24;
    localparam int ADDR_FIELD_W = 14;
    // Latched address bit 14 selects program memory
    localparam int PM_SEL_BIT = 14;

    // Overlay control register, reached as a data memory word
    localparam logic [15:0] OVERLAY_OFFSET = 16'h3fe7;
    localparam int SRO_BIT = 14;
    localparam logic [15:0] OVERLAY_RESET = 16'h0000;

    // Clock and link times in ns
    localparam int CLK_PERIOD_NS = 5;
    localparam int LATCH_MIN_NS = 10;
    localparam int ADDR_HOLD_NS = 3;
    localparam int LATCH_TO_CYCLE_NS = 3;
    localparam int READ_MIN_NS = 10;
    // Least times round up
    localparam int LATCH_MIN_CYC = (LATCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC = (LATCH_TO_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_MIN_CYC = (READ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Previous data hold in core cycles
    localparam int HOLD_DM_CYC = 2;
    localparam int HOLD_PM2_CYC = 1;
    localparam int CNT_W = 3;

    // Host controller register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // Control and status fields
    localparam int CTRL_CMD_LSB = 0;
    localparam int CTRL_SHORT_BIT = 2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;

    // Host commands
    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_LATCH,
        CMD_READ,
        CMD_WRITE
    } host_cmd_e;

endpackage : host_port_pkg

`default_nettype wire

// >>> test/host_memory_access_port_tb.sv
// Testbench for the host memory link: AHB-Lite master on the host end, device end answers.
// Assumes 200 MHz clock and the host controller register map of the package.
`timescale 1ns/1ps
`default_nettype none

module host_memory_access_port_tb;
    import host_port_pkg::*;
    logic clock, sys_rst, strap, coreWr, hsel, hwrite, hreadyOut, hresp, portEn, sro, busy;
    logic [15:0] coreData;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    int errCount = 0;
    int cmpCount = 0;
    // Rows: address, two words written, two words expected back
    logic [15:0] rows [0:2][0:4] = '{'{16'h0100, 16'h1234, 16'hfedc, 16'h1234, 16'hfedc},
        '{16'h4010, 16'hbeef, 16'hab12, 16'hbeef, 16'h0012}, '{16'h4000, 16'h0000, 16'hffff, 16'h0000, 16'h00ff}};

    host_port_if host_port_if_inst ();
    host_port_device host_port_device_inst (.clock(clock), .sys_rst(sys_rst), .link(host_port_if_inst.device),
        .strapHostPort(strap), .coreOverlayWrite(coreWr), .coreOverlayData(coreData), .portEnabled(portEn),
        .shortReadOnly(sro), .busy(busy));
    host_port_host host_port_host_inst (.clock(clock), .sys_rst(sys_rst), .link(host_port_if_inst.host),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyOut), .hreadyout(hreadyOut), .hresp(hresp), .hrdata(hrdata));
    host_port_chk host_port_chk_inst (.clock(clock), .sys_rst(sys_rst), .portSelectN(host_port_if_inst.portSelectN),
        .addrLatch(host_port_if_inst.addrLatch), .readStrobeN(host_port_if_inst.readStrobeN),
        .writeStrobeN(host_port_if_inst.writeStrobeN), .acknowledgeN(host_port_if_inst.acknowledgeN),
        .devBusOut(host_port_if_inst.devBusOut), .devBusOeN(host_port_if_inst.devBusOeN),
        .hostBusOeN(host_port_if_inst.hostBusOeN), .busLevel(host_port_if_inst.busLevel));

    // Compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmpCount++;
        if (g !== e)
        begin
            errCount++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One AHB-Lite single transfer; read data lands in q
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hreadyOut !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyOut !== 1'b1);
        q = hrdata;
    endtask : ahb

    // Start a link command and poll until done
    task automatic cmd(input logic [2:0] c);
        ahb(1'b1, 32'(REG_CTRL), 32'(c));
        q = '0;
        repeat (40)
            if (q[STAT_DONE_BIT] !== 1'b1)
                ahb(1'b0, 32'(REG_STATUS), '0);
        chk("done", 1, q[STAT_DONE_BIT]);
    endtask : cmd

    task automatic latch(input logic [15:0] a);
        ahb(1'b1, 32'(REG_ADDR), {16'h0, a});
        cmd(CMD_LATCH);
    endtask : latch

    task automatic put(input logic [15:0] d);
        ahb(1'b1, 32'(REG_WDATA), {16'h0, d});
        cmd(CMD_WRITE);
    endtask : put

    task automatic get(input string n, input logic [15:0] e, input logic [2:0] c = 3'(CMD_READ));
        cmd(c);
        ahb(1'b0, 32'(REG_RDATA), '0);
        chk(n, {16'h0, e}, q);
    endtask : get

    task automatic endOfTest();
        $display("Comparisons %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : endOfTest

    // Clock
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clock);
        errCount++;
        endOfTest();
    end

    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        strap = 1'b1;
        coreWr = 1'b0;
        coreData = '0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = '0;
        haddr = '0;
        hwdata = '0;
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        strap <= 1'b0;
        repeat (2) @(posedge clock);
        chk("strap kept", 1, portEn);
        chk("ack ready", 0, host_port_if_inst.acknowledgeN);
        chk("sro reset", 0, sro);
        chk("idle", 0, busy);
        ahb(1'b0, 32'h14, '0);
        chk("unmapped", 0, q);
        chk("okay", 0, hresp);
        foreach (rows[i])
        begin
            latch(rows[i][0]);
            put(rows[i][1]);
            put(rows[i][2]);
            latch(rows[i][0]);
            get("word lo", rows[i][3]);
            get("word hi", rows[i][4]);
        end
        // Short-read-only set by the host, then previous words come back
        latch(OVERLAY_OFFSET);
        put(16'h4000);
        chk("sro set", 1, sro);
        latch(16'h0100);
        cmd(CMD_READ);
        get("sro prev", 16'h1234);
        get("sro next", 16'hfedc);
        // Core clears the mode, host reads the register back
        @(posedge clock);
        coreData <= 16'h0005;
        coreWr <= 1'b1;
        @(posedge clock);
        coreWr <= 1'b0;
        @(posedge clock);
        chk("sro core", 0, sro);
        latch(OVERLAY_OFFSET);
        get("overlay", 16'h0005);
        // Plain short style with the bit clear: previous word, then the late fetch
        latch(16'h0100);
        get("short prev", 16'h0005, 3'h6);
        get("short late", 16'h1234, 3'h6);
        // Reset with the strap low keeps the port off
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
        chk("strap off", 0, portEn);
        chk("ack off", 1, host_port_if_inst.acknowledgeN);
        endOfTest();
    end
endmodule : host_memory_access_port_tb

`default_nettype wire

// >>> test/host_port_chk.sv
// Checker for the host memory link: device answers and host pacing on the wires.
// Assumes one clock domain; inputs are the interface signals, connected by name.
`timescale 1ns/1ps
`default_nettype none

module host_port_chk
    import host_port_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic portSelectN,
    input wire logic addrLatch,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic acknowledgeN,
    input wire logic [host_port_pkg::DATA_W-1:0] devBusOut,
    input wire logic devBusOeN,
    input wire logic hostBusOeN,
    input wire logic [host_port_pkg::DATA_W-1:0] busLevel
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic rdAct;
    logic latchAct;
    // Read and latch phases on the wires
    assign rdAct = !portSelectN && !readStrobeN;
    assign latchAct = !portSelectN && addrLatch;

    // Read start, then busy for a bounded time
    sequence rdStart;
        $rose(rdAct);
    endsequence
    sequence ackDone;
        acknowledgeN [*3] ##[1:4] !acknowledgeN;
    endsequence

    chk_ack_busy_read: assert property (rdStart |=> acknowledgeN) else $error("ack not busy");
    chk_ack_read_done: assert property (rdStart |=> ackDone) else $error("ack timing wrong");
    chk_prev_data_on: assert property (rdStart |=> !devBusOeN) else $error("bus not driven");
    chk_prev_data_hold: assert property (rdStart |=> ##1 $stable(devBusOut)) else $error("hold short");
    chk_data_steady: assert property (rdAct && $past(rdAct) && !acknowledgeN |-> !devBusOeN && $stable(devBusOut))
        else $error("read data moved");
    chk_bus_release: assert property ($fell(rdAct) |=> devBusOeN) else $error("bus not released");
    chk_latch_after_ack: assert property ($rose(latchAct) |-> !acknowledgeN) else $error("latch while busy");
    chk_read_after_ack: assert property (rdStart |-> !acknowledgeN) else $error("read while busy");
    chk_cycle_no_latch: assert property (!portSelectN && !(readStrobeN && writeStrobeN) |-> !addrLatch)
        else $error("cycle during latch");
    // Long reads only; a plain short read ends while still busy
    chk_read_holds: assert property ($fell(rdAct) && $past(rdAct, 3) |-> $past(acknowledgeN) == 1'b0)
        else $error("read cut");
    chk_addr_hold: assert property ($fell(latchAct) |-> !hostBusOeN && $stable(busLevel)) else $error("addr");
endmodule : host_port_chk

`default_nettype wire
